// file: include/reset_out_pkg.sv
// Constants shared by the reset-out pin selection block
package reset_out_pkg;
  localparam logic RESET_OUT_ASSERTED = 1'b0;
  localparam logic RESET_OUT_NEGATED = 1'b1;
  localparam logic RESET_OUT_RST_VALUE = 1'b0;
  localparam int SYNC_STAGES = 2;
  localparam logic SYNC_RST_VALUE = 1'b0;
  localparam logic RESET_IN_IDLE = 1'b1;
endpackage : reset_out_pkg

// file: hw/reset_in_sync.sv
// Synchroniser chain for the external reset input with stop-mode bypass
`timescale 1ns/1ns
module reset_in_sync #(
  parameter int STAGES = reset_out_pkg::SYNC_STAGES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Data
  input wire logic rawIn,
  input wire logic bypass,
  output logic syncOut
);
  logic [STAGES-1:0] chain_r;

  // Reset to the idle pin level so release shows no false request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chain_r <= {STAGES{reset_out_pkg::RESET_IN_IDLE}};
    end else begin
      chain_r <= {chain_r[STAGES-2:0], rawIn};
    end
  end

  assign syncOut = bypass ? rawIn : chain_r[STAGES-1];
endmodule : reset_in_sync

// file: hw/reset_out_pin_select.sv
// Reset-out pin priority selection and reset-in input conditioning
`timescale 1ns/1ns
module reset_out_pin_select (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Sources for the reset-out pin
  input wire logic sysResetActive,
  input wire logic forceResetOutBit,
  input wire logic showInterruptBit,
  input wire logic irqPending,
  // Reset-out pin
  output logic resetOutPin,
  output logic resetOutOeN,
  // Reset-in pin
  input wire logic resetInPin,
  input wire logic stopMode,
  output logic resetInSynced,
  // General pin input conditioning
  input wire logic gpioPinIn,
  input wire logic gpioMode,
  output logic gpioPinValue,
  // Boundary scan paths
  input wire logic scanMode,
  input wire logic resetOutPadIn,
  input wire logic scanResetInOut,
  input wire logic scanResetInOe,
  output logic scanResetOutIn,
  output logic resetInPadOut,
  output logic resetInPadOeN
);
  logic resetOut_nxt;
  logic resetOut_r;
  logic resetInSync;
  logic gpio1_r;
  logic gpio2_r;

  always_comb begin
    if (sysResetActive) begin
      resetOut_nxt = reset_out_pkg::RESET_OUT_ASSERTED;
    end else if (forceResetOutBit) begin
      resetOut_nxt = reset_out_pkg::RESET_OUT_ASSERTED;
    end else if (showInterruptBit) begin
      resetOut_nxt = irqPending ? reset_out_pkg::RESET_OUT_ASSERTED
                                : reset_out_pkg::RESET_OUT_NEGATED;
    end else begin
      resetOut_nxt = reset_out_pkg::RESET_OUT_NEGATED;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      resetOut_r <= reset_out_pkg::RESET_OUT_RST_VALUE;
    end else begin
      resetOut_r <= resetOut_nxt;
    end
  end

  assign resetOutPin = resetOut_r;

  // Pin is always driven; the enable still comes from a flop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      resetOutOeN <= 1'b0;
    end else begin
      resetOutOeN <= 1'b0;
    end
  end

  reset_in_sync #(.STAGES(reset_out_pkg::SYNC_STAGES)) u_reset_in_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rawIn(resetInPin),
    .bypass(stopMode),
    .syncOut(resetInSync)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gpio1_r <= reset_out_pkg::SYNC_RST_VALUE;
      gpio2_r <= reset_out_pkg::SYNC_RST_VALUE;
      gpioPinValue <= reset_out_pkg::SYNC_RST_VALUE;
      resetInSynced <= reset_out_pkg::RESET_OUT_NEGATED;
    end else begin
      gpio1_r <= gpioPinIn;
      gpio2_r <= gpio1_r;
      gpioPinValue <= gpioMode ? gpio2_r : gpioPinIn;
      resetInSynced <= resetInSync;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scanResetOutIn <= 1'b0;
      resetInPadOut <= 1'b0;
      resetInPadOeN <= 1'b1;
    end else begin
      scanResetOutIn <= scanMode ? resetOutPadIn : 1'b0;
      resetInPadOut <= scanMode ? scanResetInOut : 1'b0;
      resetInPadOeN <= !(scanMode && scanResetInOe);
    end
  end

  property p_reset_dominates;
    @(posedge sys_clk) disable iff (!rstn)
    sysResetActive |=> resetOutPin == 1'b0;
  endproperty
  a_reset_dominates: assert property (p_reset_dominates)
    else $error("reset-out not low during system reset");

  property p_force;
    @(posedge sys_clk) disable iff (!rstn)
    !sysResetActive && forceResetOutBit |=> resetOutPin == 1'b0;
  endproperty
  a_force: assert property (p_force)
    else $error("reset-out not low while forced");

  property p_show_int;
    @(posedge sys_clk) disable iff (!rstn)
    !sysResetActive && !forceResetOutBit && showInterruptBit
      |=> resetOutPin == !$past(irqPending);
  endproperty
  a_show_int: assert property (p_show_int)
    else $error("reset-out does not mirror interrupt");

  property p_negated;
    @(posedge sys_clk) disable iff (!rstn)
    !sysResetActive && !forceResetOutBit && !showInterruptBit
      |=> resetOutPin == 1'b1;
  endproperty
  a_negated: assert property (p_negated)
    else $error("reset-out not negated when idle");

  property p_sync_delay;
    @(posedge sys_clk) disable iff (!rstn)
    !stopMode [*3] |-> resetInSynced == $past(resetInPin, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("reset-in synchroniser latency wrong");

  property p_gpio_sync;
    @(posedge sys_clk) disable iff (!rstn)
    gpioMode ##1 gpioMode ##1 gpioMode |=> gpioPinValue == $past(gpioPinIn, 3);
  endproperty
  a_gpio_sync: assert property (p_gpio_sync)
    else $error("gpio input not synchronised");

  property p_scan_only;
    @(posedge sys_clk) disable iff (!rstn)
    !scanMode |=> resetInPadOeN && !scanResetOutIn && !resetInPadOut;
  endproperty
  a_scan_only: assert property (p_scan_only)
    else $error("scan path active outside scan mode");

  property p_stable;
    @(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> resetOutPin == !($past(sysResetActive) || $past(forceResetOutBit)
      || ($past(showInterruptBit) && $past(irqPending)));
  endproperty
  a_stable: assert property (p_stable)
    else $error("reset-out not the registered priority result");

  property p_force_over_show;
    @(posedge sys_clk) disable iff (!rstn)
    !sysResetActive && forceResetOutBit && showInterruptBit && !irqPending
      |=> resetOutPin == 1'b0;
  endproperty
  a_force_over_show: assert property (p_force_over_show)
    else $error("show-interrupt overrode the force bit");

  property p_show_idle;
    @(posedge sys_clk) disable iff (!rstn)
    !sysResetActive && !forceResetOutBit && showInterruptBit && !irqPending
      |=> resetOutPin == 1'b1;
  endproperty
  a_show_idle: assert property (p_show_idle)
    else $error("reset-out low with no interrupt pending");

  property p_irq_hidden;
    @(posedge sys_clk) disable iff (!rstn)
    !sysResetActive && !forceResetOutBit && !showInterruptBit && irqPending
      |=> resetOutPin == 1'b1;
  endproperty
  a_irq_hidden: assert property (p_irq_hidden)
    else $error("interrupt shown with show-interrupt clear");

  property p_stop_bypass;
    @(posedge sys_clk) disable iff (!rstn)
    stopMode |=> resetInSynced == $past(resetInPin);
  endproperty
  a_stop_bypass: assert property (p_stop_bypass)
    else $error("reset-in not passed straight in stop mode");

  property p_plain_input;
    @(posedge sys_clk) disable iff (!rstn)
    !gpioMode |=> gpioPinValue == $past(gpioPinIn);
  endproperty
  a_plain_input: assert property (p_plain_input)
    else $error("plain pin input not registered once");

  property p_scan_in;
    @(posedge sys_clk) disable iff (!rstn)
    scanMode |=> scanResetOutIn == $past(resetOutPadIn);
  endproperty
  a_scan_in: assert property (p_scan_in)
    else $error("reset-out pad input not passed in scan");

  property p_scan_out;
    @(posedge sys_clk) disable iff (!rstn)
    scanMode |=> resetInPadOut == $past(scanResetInOut);
  endproperty
  a_scan_out: assert property (p_scan_out)
    else $error("reset-in pad output not driven in scan");

  property p_scan_oe;
    @(posedge sys_clk) disable iff (!rstn)
    scanMode |=> resetInPadOeN == !$past(scanResetInOe);
  endproperty
  a_scan_oe: assert property (p_scan_oe)
    else $error("reset-in pad enable wrong in scan");
endmodule : reset_out_pin_select

// file: testbench/board_model.sv
// Board-side model that requests reset and watches the reset-out pin
`timescale 1ns/1ns
module board_model (
  // Clock
  input wire logic sys_clk,
  // Reset indication and request
  input wire logic resetOutPin,
  input wire logic pinReq,
  output logic resetInPin,
  output logic cfgDrive
);
  assign resetInPin = ~pinReq;
  // Drives config only while its own request also shows reset
  always_ff @(posedge sys_clk) begin
    cfgDrive <= ~resetOutPin & ~resetInPin;
  end
endmodule : board_model

// file: testbench/reset_out_pin_select_tb.sv
// Self-checking bench for the reset-out pin selection block
`timescale 1ns/1ns
module reset_out_pin_select_tb;
  logic sys_clk, rstn, pinReq, stopMode, gpioPinIn, gpioMode, scanMode;
  logic padIn, scanOut, scanOe, resetOutPin, resetOutOeN, resetInPin;
  logic resetInSynced, gpioPinValue, scanResetOutIn, resetInPadOut;
  logic resetInPadOeN;
  logic [3:0] src;
  int failures, num_checks;
  // Rows: system reset, force, show, irq, expected pin
  logic [4:0] rows [8] = '{5'h10, 5'h08, 5'h0c, 5'h06, 5'h05, 5'h03,
    5'h01, 5'h12};
  reset_out_pin_select u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .sysResetActive(src[3]), .forceResetOutBit(src[2]),
    .showInterruptBit(src[1]), .irqPending(src[0]),
    .resetOutPin(resetOutPin), .resetOutOeN(resetOutOeN),
    .resetInPin(resetInPin), .stopMode(stopMode),
    .resetInSynced(resetInSynced), .gpioPinIn(gpioPinIn),
    .gpioMode(gpioMode), .gpioPinValue(gpioPinValue),
    .scanMode(scanMode), .resetOutPadIn(padIn),
    .scanResetInOut(scanOut), .scanResetInOe(scanOe),
    .scanResetOutIn(scanResetOutIn), .resetInPadOut(resetInPadOut),
    .resetInPadOeN(resetInPadOeN));
  board_model u_board (.sys_clk(sys_clk), .resetOutPin(resetOutPin),
    .pinReq(pinReq), .resetInPin(resetInPin), .cfgDrive());
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic complete_run;
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #2000;
    failures++;
    complete_run();
  end
  initial begin
    {rstn, src, pinReq, stopMode, gpioPinIn, gpioMode} = '0;
    {scanMode, padIn, scanOut, scanOe} = '0;
    failures = 0;
    num_checks = 0;
    step(5);
    chk(resetOutPin, 1'b0);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      src = rows[i][4:1];
      step(1);
      chk(resetOutPin, rows[i][0]);
    end
    chk(resetOutOeN, 1'b0);
    pinReq = 1'b1;
    step(2);
    chk(resetInSynced, 1'b1);
    step(1);
    chk(resetInSynced, 1'b0);
    stopMode = 1'b1;
    pinReq = 1'b0;
    step(1);
    chk(resetInSynced, 1'b1);
    gpioMode = 1'b1;
    gpioPinIn = 1'b1;
    step(2);
    chk(gpioPinValue, 1'b0);
    step(1);
    chk(gpioPinValue, 1'b1);
    gpioMode = 1'b0;
    gpioPinIn = 1'b0;
    step(1);
    chk(gpioPinValue, 1'b0);
    {padIn, scanOut, scanOe, src} = 7'h70;
    step(1);
    chk(scanResetOutIn, 1'b0);
    chk(resetInPadOut, 1'b0);
    chk(resetInPadOeN, 1'b1);
    scanMode = 1'b1;
    step(1);
    chk(scanResetOutIn, 1'b1);
    chk(resetInPadOut, 1'b1);
    chk(resetOutPin, 1'b1);
    chk(resetInPadOeN, 1'b0);
    step(1);
    rstn = 1'b0;
    #2;
    chk(resetOutPin, 1'b0);
    chk(resetInSynced, 1'b1);
    chk(resetInPadOeN, 1'b1);
    complete_run();
  end
endmodule : reset_out_pin_select_tb
